// [design/dcf_top.v]
// Derived clocks, clock outputs and input noise filters with AXI4-Lite registers
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "dcf_defines.vh"

module dcf_top
(
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// Write address channel
	input  wire [31:0] s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// Write data channel
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// Write response channel
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// Read address channel
	input  wire [31:0] s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// Read data channel
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Clock sources, sampled levels
	input  wire        main_clock,
	input  wire        sub_clock,
	// Derived clocks and system clock source select
	output wire        display_driver_clock,
	output wire        sub_clock_8bit_timer,
	output wire        system_clock_source_select,
	// Oscillator control levels
	output wire        main_osc_enable,
	output wire        sub_osc_enable,
	output wire [1:0]  main_osc_wait_select,
	// General port side of shared pin a
	input  wire        port_a_data,
	input  wire        port_a_drive,
	// Shared pin a
	output wire        shared_port_pin_a_o,
	output wire        shared_port_pin_a_oe,
	// General port side of shared pin b
	input  wire        port_b_data,
	input  wire        port_b_drive,
	// Shared pin b
	output wire        shared_port_pin_b_o,
	output wire        shared_port_pin_b_oe,
	// Core request inputs
	input  wire        reset_request_in,
	input  wire        wdt_nmi_request,
	// Filtered core requests
	output wire        core_reset_request,
	output wire        core_nmi_request
);

	// =========================================
	// Functions

	// Address to {hit, register number}
	function [3:0] reg_decode;
		input [31:0] addr;
		begin
			reg_decode = 4'h0;
			if (addr[1:0] == 2'h0)
			begin
				case (addr[31:2])
					{14'h0000, `DCF_IDX_SRC}:  reg_decode = {1'b1, `DCF_REG_SRC};
					{14'h0000, `DCF_IDX_CTL}:  reg_decode = {1'b1, `DCF_REG_CTL};
					{14'h0000, `DCF_IDX_NFEN}: reg_decode = {1'b1, `DCF_REG_NFEN};
					{14'h0000, `DCF_IDX_DISP}: reg_decode = {1'b1, `DCF_REG_DISP};
					{14'h0000, `DCF_IDX_FOUT}: reg_decode = {1'b1, `DCF_REG_FOUT};
					{14'h0000, `DCF_IDX_T8}:   reg_decode = {1'b1, `DCF_REG_T8};
					{14'h0000, `DCF_IDX_PMUX}: reg_decode = {1'b1, `DCF_REG_PMUX};
					default:                   reg_decode = 4'h0;
				endcase
			end
		end
	endfunction

	// Field code to power of two, reserved codes clamp to largest ratio
	function [3:0] code_to_log2;
		input [2:0] code;
		input [3:0] base;
		input [3:0] max;
		reg   [3:0] sum;
		begin
			sum = base + {1'b0, code};
			if (sum > max)
				code_to_log2 = max;
			else
				code_to_log2 = sum;
		end
	endfunction

	// =========================================
	// Registers
	reg [7:0]  src_ff;
	reg [7:0]  ctl_ff;
	reg [7:0]  nfen_ff;
	reg [7:0]  disp_ff;
	reg [7:0]  fout_ff;
	reg [7:0]  t8_ff;
	reg [7:0]  pmux_ff;

	// Bus state
	reg        aw_held_ff;
	reg [31:0] awaddr_ff;
	reg        w_held_ff;
	reg [7:0]  wdata_ff;
	reg        wlane_ff;
	wire       aw_take;
	wire       w_take;
	wire       ar_take;
	wire       write_go;
	wire [3:0] wr_dec;
	wire [3:0] rd_dec;
	reg  [7:0] rd_value;
	reg  [7:0] nxt_wr_value;
	reg  [7:0] wr_mask;

	assign s_axi_awready = ~aw_held_ff & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held_ff & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign aw_take  = s_axi_awvalid & s_axi_awready;
	assign w_take   = s_axi_wvalid & s_axi_wready;
	assign ar_take  = s_axi_arvalid & s_axi_arready;
	assign write_go = aw_held_ff & w_held_ff & ~s_axi_bvalid;
	assign wr_dec   = reg_decode(awaddr_ff);
	assign rd_dec   = reg_decode(s_axi_araddr);

	// =========================================
	// Write channel capture
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_ff <= 1'b0;
			awaddr_ff  <= 32'h00000000;
			w_held_ff  <= 1'b0;
			wdata_ff   <= 8'h00;
			wlane_ff   <= 1'b0;
		end
		else
		begin
			if (aw_take)
			begin
				aw_held_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
			end
			else if (write_go)
				aw_held_ff <= 1'b0;
			if (w_take)
			begin
				w_held_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata[7:0];
				wlane_ff  <= s_axi_wstrb[0];
			end
			else if (write_go)
				w_held_ff <= 1'b0;
		end
	end

	// =========================================
	// Write mask of the addressed register
	always @*
	begin
		case (wr_dec[2:0])
			`DCF_REG_SRC:  wr_mask = `DCF_MASK_SRC;
			`DCF_REG_CTL:  wr_mask = `DCF_MASK_CTL;
			`DCF_REG_NFEN: wr_mask = `DCF_MASK_NFEN;
			`DCF_REG_DISP: wr_mask = `DCF_MASK_DISP;
			`DCF_REG_FOUT: wr_mask = `DCF_MASK_FOUT;
			`DCF_REG_T8:   wr_mask = `DCF_MASK_T8;
			`DCF_REG_PMUX: wr_mask = `DCF_MASK_PMUX;
			default:       wr_mask = 8'h00;
		endcase
		nxt_wr_value = wdata_ff & wr_mask;
	end

	// =========================================
	// Register file and write response
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			src_ff       <= `DCF_RST_SRC;
			ctl_ff       <= `DCF_RST_CTL;
			nfen_ff      <= `DCF_RST_NFEN;
			disp_ff      <= `DCF_RST_DISP;
			fout_ff      <= `DCF_RST_FOUT;
			t8_ff        <= `DCF_RST_T8;
			pmux_ff      <= `DCF_RST_PMUX;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `DCF_RESP_OKAY;
		end
		else
		begin
			if (write_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_dec[3] ? `DCF_RESP_OKAY : `DCF_RESP_SLVERR;
				if (wr_dec[3] && wlane_ff)
				begin
					case (wr_dec[2:0])
						`DCF_REG_SRC:  src_ff  <= nxt_wr_value;
						`DCF_REG_CTL:  ctl_ff  <= nxt_wr_value;
						`DCF_REG_NFEN: nfen_ff <= nxt_wr_value;
						`DCF_REG_DISP: disp_ff <= nxt_wr_value;
						`DCF_REG_FOUT: fout_ff <= nxt_wr_value;
						`DCF_REG_T8:   t8_ff   <= nxt_wr_value;
						`DCF_REG_PMUX: pmux_ff <= nxt_wr_value;
						default:       src_ff  <= src_ff;
					endcase
				end
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// =========================================
	// Read path
	always @*
	begin
		case (rd_dec[2:0])
			`DCF_REG_SRC:  rd_value = src_ff;
			`DCF_REG_CTL:  rd_value = ctl_ff;
			`DCF_REG_NFEN: rd_value = nfen_ff;
			`DCF_REG_DISP: rd_value = disp_ff;
			`DCF_REG_FOUT: rd_value = fout_ff;
			`DCF_REG_T8:   rd_value = t8_ff;
			`DCF_REG_PMUX: rd_value = pmux_ff;
			default:       rd_value = 8'h00;
		endcase
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `DCF_RESP_OKAY;
		end
		else if (ar_take)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_dec[3] ? {24'h000000, rd_value} : 32'h00000000;
			s_axi_rresp  <= rd_dec[3] ? `DCF_RESP_OKAY : `DCF_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// =========================================
	// Control fields
	wire       sys_src_sub;
	wire       lcd_enable;
	wire       lcd_src_sub;
	wire [2:0] lcd_code;
	wire       t8_enable;
	wire [2:0] t8_code;
	wire       main_out_en;
	wire       sub_out_en;
	wire [1:0] main_out_code;
	wire       main_output_pin_select;
	wire       sub_output_pin_select;
	wire       reset_filter_enable;
	wire       interrupt_filter_enable;

	assign sys_src_sub             = src_ff[0];
	assign lcd_enable              = disp_ff[0];
	assign lcd_src_sub             = disp_ff[1];
	assign lcd_code                = disp_ff[4:2];
	assign t8_enable               = t8_ff[0];
	assign t8_code                 = t8_ff[3:1];
	assign sub_out_en              = fout_ff[0];
	assign main_out_en             = fout_ff[1];
	assign main_out_code           = fout_ff[3:2];
	assign main_output_pin_select  = pmux_ff[0];
	assign sub_output_pin_select   = pmux_ff[3];
	assign interrupt_filter_enable = nfen_ff[0];
	assign reset_filter_enable     = nfen_ff[1];

	assign system_clock_source_select = sys_src_sub;
	assign main_osc_enable            = ctl_ff[0];
	assign sub_osc_enable             = ctl_ff[1];
	assign main_osc_wait_select       = ctl_ff[5:4];

	// =========================================
	// Dividers
	wire [3:0] lcd_log2;
	wire [3:0] t8_log2;
	wire [3:0] fout_log2;
	wire       lcd_div_clock;
	wire       t8_div_clock;
	wire       main_div_clock;

	assign lcd_log2  = code_to_log2(lcd_code, `DCF_LCD_LOG2_BASE, `DCF_LCD_LOG2_MAX);
	assign t8_log2   = code_to_log2(t8_code, 4'h0, `DCF_T8_LOG2_MAX);
	assign fout_log2 = code_to_log2({1'b0, main_out_code}, 4'h0, `DCF_FOUT_LOG2_MAX);

	dcf_clock_divider u_lcd_div
	(
		.aclk       (aclk),
		.aresetn    (aresetn),
		.src_level  (main_clock),
		.ratio_log2 (lcd_log2),
		.div_clock  (lcd_div_clock)
	);

	dcf_clock_divider u_t8_div
	(
		.aclk       (aclk),
		.aresetn    (aresetn),
		.src_level  (sub_clock),
		.ratio_log2 (t8_log2),
		.div_clock  (t8_div_clock)
	);

	dcf_clock_divider u_fout_div
	(
		.aclk       (aclk),
		.aresetn    (aresetn),
		.src_level  (main_clock),
		.ratio_log2 (fout_log2),
		.div_clock  (main_div_clock)
	);

	// =========================================
	// Gated clocks, plain gates with no resync
	wire main_clock_output;
	wire sub_clock_output;

	assign display_driver_clock = lcd_enable & (lcd_src_sub ? sub_clock : lcd_div_clock);
	assign sub_clock_8bit_timer = t8_enable & t8_div_clock;
	assign main_clock_output    = main_out_en & main_div_clock;
	assign sub_clock_output     = sub_out_en & sub_clock;

	// =========================================
	// Shared pins
	assign shared_port_pin_a_o  = main_output_pin_select ? main_clock_output : port_a_data;
	assign shared_port_pin_a_oe = main_output_pin_select | port_a_drive;
	assign shared_port_pin_b_o  = sub_output_pin_select ? sub_clock_output : port_b_data;
	assign shared_port_pin_b_oe = sub_output_pin_select | port_b_drive;

	// =========================================
	// Filter tick from system clock edges
	reg        sys_prev_ff;
	reg  [2:0] filt_count_ff;
	reg        filt_tick_ff;
	wire       sys_level;
	wire       sys_rise;

	assign sys_level = sys_src_sub ? sub_clock : main_clock;
	assign sys_rise  = sys_level & ~sys_prev_ff;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sys_prev_ff   <= 1'b0;
			filt_count_ff <= 3'h0;
			filt_tick_ff  <= 1'b0;
		end
		else
		begin
			sys_prev_ff  <= sys_level;
			filt_tick_ff <= sys_rise && (filt_count_ff == `DCF_FILT_DIV_LAST);
			if (sys_rise)
				filt_count_ff <= filt_count_ff + 3'h1;
		end
	end

	// =========================================
	// Noise filters
	dcf_noise_filter u_reset_filter
	(
		.aclk      (aclk),
		.aresetn   (aresetn),
		.tick      (filt_tick_ff),
		.enable    (reset_filter_enable),
		.raw_in    (reset_request_in),
		.clean_out (core_reset_request)
	);

	dcf_noise_filter u_nmi_filter
	(
		.aclk      (aclk),
		.aresetn   (aresetn),
		.tick      (filt_tick_ff),
		.enable    (interrupt_filter_enable),
		.raw_in    (wdt_nmi_request),
		.clean_out (core_nmi_request)
	);

endmodule // dcf_top

`default_nettype wire

// [design/dcf_defines.vh]
// Register map, writable masks, reset values and ratios of the derived clock block
`ifndef DCF_DEFINES_VH
`define DCF_DEFINES_VH

// Register indices; byte address is four times the index
`define DCF_IDX_SRC      16'h5060
`define DCF_IDX_CTL      16'h5061
`define DCF_IDX_NFEN     16'h5062
`define DCF_IDX_DISP     16'h5063
`define DCF_IDX_FOUT     16'h5064
`define DCF_IDX_T8       16'h5065
`define DCF_IDX_PMUX     16'h5066

// Register numbers inside the block
`define DCF_REG_SRC      3'h0
`define DCF_REG_CTL      3'h1
`define DCF_REG_NFEN     3'h2
`define DCF_REG_DISP     3'h3
`define DCF_REG_FOUT     3'h4
`define DCF_REG_T8       3'h5
`define DCF_REG_PMUX     3'h6

// Writable bit masks; other bits are reserved and read zero
`define DCF_MASK_SRC     8'h01
`define DCF_MASK_CTL     8'h33
`define DCF_MASK_NFEN    8'h03
`define DCF_MASK_DISP    8'h1f
`define DCF_MASK_FOUT    8'h0f
`define DCF_MASK_T8      8'h0f
`define DCF_MASK_PMUX    8'h09

// Reset values
`define DCF_RST_SRC      8'h00
`define DCF_RST_CTL      8'h03
`define DCF_RST_NFEN     8'h02
`define DCF_RST_DISP     8'h02
`define DCF_RST_FOUT     8'h00
`define DCF_RST_T8       8'h00
`define DCF_RST_PMUX     8'h00

// Division as power of two of the source
`define DCF_LCD_LOG2_BASE 4'h5
`define DCF_LCD_LOG2_MAX  4'h9
`define DCF_T8_LOG2_MAX   4'h5
`define DCF_FOUT_LOG2_MAX 4'h2

// Noise filter runs on system clock divided by eight
`define DCF_FILT_DIV_LAST 3'h7

// Bus answers
`define DCF_RESP_OKAY    2'h0
`define DCF_RESP_SLVERR  2'h2

`endif

// [design/dcf_clock_divider.v]
// Power-of-two divider of a sampled clock level
`timescale 1ns/1ps
`default_nettype none

module dcf_clock_divider
(
	// System
	input  wire       aclk,
	input  wire       aresetn,
	// Source and ratio
	input  wire       src_level,
	input  wire [3:0] ratio_log2,
	// Divided clock
	output reg        div_clock
);

	reg       src_prev_ff;
	reg [8:0] count_ff;
	wire      src_rise;

	assign src_rise = src_level & ~src_prev_ff;

	// =========================================
	// Counter of source rising edges
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			src_prev_ff <= 1'b0;
			count_ff    <= 9'h000;
		end
		else
		begin
			src_prev_ff <= src_level;
			if (src_rise)
				count_ff <= count_ff + 9'h001;
		end
	end

	// =========================================
	// Output select, ratio one passes the source
	always @*
	begin
		if (ratio_log2 == 4'h0)
			div_clock = src_level;
		else
			div_clock = count_ff[ratio_log2 - 4'h1];
	end

endmodule // dcf_clock_divider

`default_nettype wire

// [design/dcf_noise_filter.v]
// Two-tick noise filter with bypass
`timescale 1ns/1ps
`default_nettype none

module dcf_noise_filter
(
	// System
	input  wire aclk,
	input  wire aresetn,
	// Filter control
	input  wire tick,
	input  wire enable,
	// Signal
	input  wire raw_in,
	output wire clean_out
);

	reg sample_ff;
	reg state_ff;

	// =========================================
	// Level accepted after two equal tick samples
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sample_ff <= 1'b0;
			state_ff  <= 1'b0;
		end
		else if (tick)
		begin
			sample_ff <= raw_in;
			if (sample_ff == raw_in)
				state_ff <= raw_in;
		end
	end

	// Bypass passes the input straight on
	assign clean_out = enable ? state_ff : raw_in;

endmodule // dcf_noise_filter

`default_nettype wire

// [verification/dcf_top_chk.sv]
// Port checker for the derived clock block
`timescale 1ns/1ps
`default_nettype none

module dcf_top_chk
(
	// System
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Clocks and pins
	input wire logic        display_driver_clock,
	input wire logic        sub_clock_8bit_timer,
	input wire logic        system_clock_source_select,
	input wire logic        port_a_drive,
	input wire logic        shared_port_pin_a_oe,
	input wire logic        port_b_drive,
	input wire logic        shared_port_pin_b_oe,
	// Core requests
	input wire logic        wdt_nmi_request,
	input wire logic        core_nmi_request,
	input wire logic        core_reset_request
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ==========================================
	// Assertions
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped or changed");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped or changed");
	chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	chk_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing wrong");
	chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	chk_reset_gates: assert property ($rose(aresetn) |-> !display_driver_clock && !sub_clock_8bit_timer)
		else $error("derived clocks running after reset");
	chk_reset_src: assert property ($rose(aresetn) |-> !system_clock_source_select)
		else $error("system source not main after reset");
	chk_nmi_bypass: assert property ($rose(aresetn) |-> core_nmi_request == wdt_nmi_request)
		else $error("interrupt path not bypassed after reset");
	chk_rst_filter: assert property ($rose(aresetn) |-> !core_reset_request)
		else $error("reset path not filtered after reset");
	chk_pin_a_own: assert property (port_a_drive |-> shared_port_pin_a_oe)
		else $error("pin a drive lost");
	chk_pin_b_own: assert property (port_b_drive |-> shared_port_pin_b_oe)
		else $error("pin b drive lost");

	// ==========================================
	// Covers
	cov_write: cover property (s_axi_bvalid && s_axi_bready);
	cov_read: cover property (s_axi_rvalid && s_axi_rready);
	cov_disp: cover property ($rose(display_driver_clock));
	cov_nmi: cover property ($rose(core_nmi_request));
endmodule // dcf_top_chk

bind dcf_top dcf_top_chk u_dcf_top_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .display_driver_clock,
	.sub_clock_8bit_timer, .system_clock_source_select, .port_a_drive, .shared_port_pin_a_oe,
	.port_b_drive, .shared_port_pin_b_oe, .wdt_nmi_request, .core_nmi_request, .core_reset_request);

`default_nettype wire

// [verification/dcf_clk_src_model.sv]
// Free-running main and sub oscillator model
`timescale 1ns/1ps
`default_nettype none

module dcf_clk_src_model
#(
	parameter int HALF_MAIN = 2,
	parameter int HALF_SUB  = 3
)
(
	// System clock
	input  wire logic aclk,
	// Oscillator levels
	output var  logic main_clock = 1'b0,
	output var  logic sub_clock  = 1'b0
);
	int cm = 0;
	int cs = 0;

	// ==========================================
	// Toggle counters
	always @(posedge aclk)
	begin
		cm <= (cm == HALF_MAIN - 1) ? 0 : cm + 1;
		cs <= (cs == HALF_SUB - 1) ? 0 : cs + 1;
		if (cm == HALF_MAIN - 1)
			main_clock <= ~main_clock;
		if (cs == HALF_SUB - 1)
			sub_clock <= ~sub_clock;
	end
endmodule // dcf_clk_src_model

`default_nettype wire

// [verification/dcf_top_test.sv]
// Self-checking testbench of the derived clock block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end

module dcf_top_test;
	localparam int PM = 4;
	localparam int PS = 6;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, got;
	logic [3:0] wstrb = 0;
	logic [1:0] rsp;
	logic pad = 0, pdr = 0, pbd = 0, pbdr = 0, rreq = 0, nreq = 0, pv, probe, sn, sr;
	wire awready, wready, bvalid, arready, rvalid, mclk, sclk, dclk, tclk, src, pao, paoe;
	wire pbo, pboe, crst, cnmi, mo, so;
	wire [1:0] bresp, rresp, mw;
	wire [31:0] rdata;
	integer error_cnt = 0, n_checks = 0, cyc = 0, seed = 32'haadc, i, t0, sel, cnt;
	integer regm[0:6];
	logic [7:0] mask[0:6] = '{8'h01, 8'h33, 8'h03, 8'h1f, 8'h0f, 8'h0f, 8'h09};

	dcf_clk_src_model #(.HALF_MAIN(PM / 2), .HALF_SUB(PS / 2)) u_dcf_clk_src_model
		(.aclk(aclk), .main_clock(mclk), .sub_clock(sclk));
	dcf_top u_dcf_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .main_clock(mclk), .sub_clock(sclk),
		.display_driver_clock(dclk), .sub_clock_8bit_timer(tclk),
		.system_clock_source_select(src), .main_osc_enable(mo), .sub_osc_enable(so),
		.main_osc_wait_select(mw), .port_a_data(pad), .port_a_drive(pdr),
		.shared_port_pin_a_o(pao), .shared_port_pin_a_oe(paoe), .port_b_data(pbd),
		.port_b_drive(pbdr), .shared_port_pin_b_o(pbo), .shared_port_pin_b_oe(pboe),
		.reset_request_in(rreq), .wdt_nmi_request(nreq), .core_reset_request(crst),
		.core_nmi_request(cnmi));

	initial forever #50 aclk = ~aclk;
	always @* probe = (sel == 0) ? dclk : (sel == 1) ? tclk : (sel == 2) ? pao : pbo;

	// ==========================================
	// Closing and hang limit
	task complete_run;
	begin
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask

	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			error_cnt++;
			complete_run;
		end
	end

	// ==========================================
	// Register bus and model
	function integer ix(input [31:0] a);
		ix = (a[1:0] == 0 && a >= 32'h14180 && a <= 32'h14198) ? (a - 32'h14180) >> 2 : -1;
	endfunction

	task wr(input [31:0] a, input [7:0] d, input [3:0] s);
		logic ad, wd;
	begin
		ad = 0;
		wd = 0;
		@(posedge aclk);
		awaddr <= a; wdata <= {24'h0, d}; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			if (!ad && awready) begin ad = 1; awvalid <= 0; end
			if (!wd && wready) begin wd = 1; wvalid <= 0; end
		end
		while (!bvalid) @(posedge aclk);
		bready <= 0;
		rsp = bresp;
		if (ix(a) >= 0 && s[0]) regm[ix(a)] = d & mask[ix(a)];
		`CHK("bresp", (ix(a) < 0) ? 2'h2 : 2'h0, rsp)
	end
	endtask

	task rd(input [31:0] a);
	begin
		@(posedge aclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		@(posedge aclk);
		while (!arready) @(posedge aclk);
		arvalid <= 0;
		@(posedge aclk);
		while (!rvalid) @(posedge aclk);
		rready <= 0;
		got = rdata;
		rsp = rresp;
		`CHK("rdata", (ix(a) < 0) ? 32'h0 : regm[ix(a)], got)
		`CHK("rresp", (ix(a) < 0) ? 2'h2 : 2'h0, rsp)
	end
	endtask

	task wi(input integer j, input [7:0] d);
		wr(32'h14180 + 4 * j, d, 4'hf);
	endtask

	// ==========================================
	// Clock measurement and noise filter pulses
	task rise;
	begin
		pv = probe; @(posedge aclk); #1;
		while (!(probe && !pv)) begin pv = probe; @(posedge aclk); #1; end
	end
	endtask

	task per(input integer s, input integer e);
	begin
		sel = s; rise; rise; t0 = cyc; rise;
		`CHK("period", e, cyc - t0)
	end
	endtask

	task quiet(input integer s);
		integer k;
	begin
		sel = s; cnt = 0;
		for (k = 0; k < 200; k++) begin pv = probe; @(posedge aclk); #1; if (probe && !pv) cnt++; end
		`CHK("edges", 0, cnt)
	end
	endtask

	task pulse(input integer w);
		integer k;
	begin
		sn = 0; sr = 0;
		@(posedge aclk); nreq <= 1; rreq <= 1;
		for (k = 0; k < w + 150; k++)
		begin
			@(posedge aclk);
			if (k == w - 1) begin nreq <= 0; rreq <= 0; end
			#1; sn |= cnmi; sr |= crst;
		end
		`CHK("nmi", (w / PM >= 16), sn)
		`CHK("rst", (w / PM >= 16), sr)
	end
	endtask

	// ==========================================
	// Main sequence
	initial
	begin
		regm = '{0, 3, 2, 2, 0, 0, 0};
		sel = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		for (i = 0; i < 7; i++) rd(32'h14180 + 4 * i);
		for (i = 0; i < 21; i++) begin wi(i % 7, $random(seed)); rd(32'h14180 + 4 * (i % 7)); end
		`CHK("srcsel", regm[0][0], src)
		`CHK("oscillator_control", {regm[1][5:4], regm[1][1:0]}, {mw, so, mo})
		wr(32'h1418c, 8'hff, 4'h0); rd(32'h1418c);
		wr(32'h1419c, 8'h55, 4'hf); rd(32'h1419c); rd(32'h14181); rd(32'h0);
		wi(0, 8'h00); wi(4, 8'h00); wi(5, 8'h00); wi(6, 8'h00);
		wi(3, 8'h13); per(0, PS);
		for (i = 0; i < 5; i++) begin wi(3, i * 4 + 1); per(0, PM << (5 + i)); end
		wi(3, 8'h02); quiet(0);
		for (i = 0; i < 6; i++) begin wi(5, i * 2 + 1); per(1, PS << i); end
		wi(5, 8'h00); quiet(1);
		wi(6, 8'h01);
		for (i = 0; i < 3; i++) begin wi(4, i * 4 + 2); per(2, PM << i); `CHK("oe", 1'b1, paoe) end
		wi(4, 8'h00); quiet(2);
		wi(6, 8'h08); wi(4, 8'h01); per(3, PS);
		wi(4, 8'h00); quiet(3);
		wi(6, 8'h00);
		for (i = 0; i < 8; i++)
		begin
			@(posedge aclk); pad <= $random(seed); pdr <= $random(seed); pbd <= $random(seed);
			pbdr <= $random(seed); @(posedge aclk); #1;
			`CHK("pin_a", {pad, pdr}, {pao, paoe})
			`CHK("pin_b", {pbd, pbdr}, {pbo, pboe})
		end
		wi(2, 8'h03); pulse(24); pulse(160);
		wi(2, 8'h00); @(posedge aclk); nreq <= 1; rreq <= 1; @(posedge aclk); #1;
		`CHK("bypass", 2'h3, {cnmi, crst})
		@(posedge aclk); nreq <= 0; rreq <= 0;
		complete_run;
	end
endmodule // dcf_top_test

`default_nettype wire
